// ===== design/stpu_defs.vh
// register map, field layout, reset values and timing for the servo tuning unit
`ifndef STPU_DEFS_VH
`define STPU_DEFS_VH

// register byte addresses
`define STPU_ADDR_OVERRUN 8'h00
`define STPU_ADDR_VIB_FREQ 8'h04
`define STPU_ADDR_VIB_FILT 8'h08
`define STPU_ADDR_ADAPT_IDX 8'h0C
`define STPU_ADDR_GAIN_MODE 8'h10
`define STPU_ADDR_STATUS 8'h14

// reset values
`define STPU_RST_OVERRUN 16'h000A
`define STPU_RST_VIB_FREQ 16'h0000
`define STPU_RST_VIB_FILT 16'h0000
`define STPU_RST_ADAPT_IDX 7'h00
`define STPU_RST_GAIN_MODE 1'h1

// setting ranges
`define STPU_OVERRUN_MAX 16'h03E8
`define STPU_VIB_FREQ_MAX 16'h1388
`define STPU_VIB_FREQ_MIN_ON 16'h0064
`define STPU_VIB_FILT_MIN 16'hFF38
`define STPU_VIB_FILT_MAX 16'h09C4
`define STPU_ADAPT_IDX_MAX 7'h40

// status register bit positions
`define STPU_ST_ADAPT_EN 0
`define STPU_ST_REJECT 1
`define STPU_ST_GAIN_SET2 2
`define STPU_ST_NOTCH_ON 3

// autotune mode and control mode codes
`define STPU_CTRL_ADVANCED 2'h2
`define STPU_ATM_ADAPT_ONLY 3'h7

// gain switch condition codes handled here
`define STPU_GSC_ALWAYS1 4'h0
`define STPU_GSC_ALWAYS2 4'h1
`define STPU_GSC_INPUT 4'h2
`define STPU_GSC_ALWAYS1B 4'h4

// rigidity thresholds (D, E, F)
`define STPU_RIG_D 4'hD
`define STPU_RIG_E 4'hE
`define STPU_RIG_F 4'hF

// timing: clock rate, tick period and save period
`define STPU_CLK_HZ 50000000
`define STPU_TICK_US 1000
`define STPU_TICK_CYCLES (`STPU_CLK_HZ / 1000000 * `STPU_TICK_US)
`define STPU_SAVE_PERIOD_MIN 30
`define STPU_SAVE_TICKS (`STPU_SAVE_PERIOD_MIN * 60 * 1000000 / `STPU_TICK_US)

`endif

// ===== design/stpu_notch_table.v
// adaptive notch table: index and rigidity to notch frequency
`timescale 1ns/1ps
`include "stpu_defs.vh"
module stpu_notch_table (
  input wire [6:0] index_in,
  input wire [3:0] rigidity_in,
  output reg [10:0] freq_hz_out,
  output reg notch_on_out
);
  // frequency lookup and rigidity cut-off
  always @* begin
    case (index_in)
      7'h05: freq_hz_out = 11'h5CA;
      7'h06: freq_hz_out = 11'h592;
      7'h07: freq_hz_out = 11'h55C;
      7'h08: freq_hz_out = 11'h527;
      7'h09: freq_hz_out = 11'h4F5;
      7'h0A: freq_hz_out = 11'h4C5;
      7'h0B: freq_hz_out = 11'h496;
      7'h0C: freq_hz_out = 11'h46A;
      7'h0D: freq_hz_out = 11'h43F;
      7'h0E: freq_hz_out = 11'h415;
      7'h0F: freq_hz_out = 11'h3ED;
      7'h10: freq_hz_out = 11'h3C7;
      7'h11: freq_hz_out = 11'h3A2;
      7'h12: freq_hz_out = 11'h37F;
      7'h13: freq_hz_out = 11'h35D;
      7'h14: freq_hz_out = 11'h33C;
      7'h15: freq_hz_out = 11'h31C;
      7'h16: freq_hz_out = 11'h2FE;
      7'h17: freq_hz_out = 11'h2E1;
      7'h18: freq_hz_out = 11'h2C5;
      7'h19: freq_hz_out = 11'h2AA;
      7'h1A: freq_hz_out = 11'h290;
      7'h1B: freq_hz_out = 11'h277;
      7'h1C: freq_hz_out = 11'h25F;
      7'h1D: freq_hz_out = 11'h248;
      7'h1E: freq_hz_out = 11'h232;
      7'h1F: freq_hz_out = 11'h21C;
      7'h20: freq_hz_out = 11'h208;
      7'h21: freq_hz_out = 11'h1F4;
      7'h22: freq_hz_out = 11'h1E1;
      7'h23: freq_hz_out = 11'h1CE;
      7'h24: freq_hz_out = 11'h1BD;
      7'h25: freq_hz_out = 11'h1AC;
      7'h26: freq_hz_out = 11'h19C;
      7'h27: freq_hz_out = 11'h18C;
      7'h28: freq_hz_out = 11'h17D;
      7'h29: freq_hz_out = 11'h16E;
      7'h2A: freq_hz_out = 11'h160;
      7'h2B: freq_hz_out = 11'h153;
      7'h2C: freq_hz_out = 11'h146;
      7'h2D: freq_hz_out = 11'h13A;
      7'h2E: freq_hz_out = 11'h12E;
      7'h2F: freq_hz_out = 11'h122;
      7'h30: freq_hz_out = 11'h117;
      7'h31: freq_hz_out = 11'h10D;
      7'h32: freq_hz_out = 11'h102;
      7'h33: freq_hz_out = 11'h0F8;
      7'h34: freq_hz_out = 11'h0EF;
      7'h35: freq_hz_out = 11'h0E6;
      7'h36: freq_hz_out = 11'h0DD;
      7'h37: freq_hz_out = 11'h0D5;
      7'h38: freq_hz_out = 11'h0CD;
      7'h39: freq_hz_out = 11'h0C5;
      7'h3A: freq_hz_out = 11'h0BD;
      7'h3B: freq_hz_out = 11'h0B6;
      default: freq_hz_out = 11'h000;
    endcase
    notch_on_out = (freq_hz_out != 11'h000);
    if ((index_in >= 7'h31) && (index_in <= 7'h35) && (rigidity_in >= `STPU_RIG_F)) begin
      notch_on_out = 1'b0;
    end
    if ((index_in >= 7'h36) && (index_in <= 7'h3A) && (rigidity_in >= `STPU_RIG_E)) begin
      notch_on_out = 1'b0;
    end
    if ((index_in == 7'h3B) && (rigidity_in >= `STPU_RIG_D)) begin
      notch_on_out = 1'b0;
    end
  end
endmodule // stpu_notch_table

// ===== design/stpu_tuning_unit.v
// servo tuning parameter unit: parameter registers and their effect on the loops
//
// Contract
// - hold overrun limit 0..1000 in 0.1 rotation steps, default 10
// - overrun limit zero disables travel range checking
// - hold vibration frequency 0..5000 in 0.1 Hz, default 0
// - vibration frequency below 100 disables vibration control
// - hold signed vibration filter -200..2500 in 0.1 Hz, default 0
// - expose adaptive table index 0..64, default 0
// - adaptive filter on: hardware updates index, external writes ignored
// - adaptive filter on: save index to nonvolatile store every 30 minutes
// - power-up with adaptive on starts from the saved index
// - index 0..4 and 60..64 off, 5..59 map 1482 Hz down to 182 Hz
// - high indices disabled by rigidity F, E or D and above
// - hold one-bit gain switching mode, default 1
// - switching off: gain select input picks PI or P speed loop
// - switching on: gain set chosen by gain switch condition
// - index returns to zero when adaptive filter becomes disabled
// - switching off uses gain set 1 only, on picks set 1 or 2 by the condition
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "stpu_defs.vh"
module stpu_tuning_unit #(
  parameter TICK_CYCLES = `STPU_TICK_CYCLES,
  parameter SAVE_TICKS = `STPU_SAVE_TICKS
) (
  input wire clk_sys_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  input wire [2:0] realtime_autotune_mode_in,
  input wire [3:0] machine_rigidity_level_in,
  input wire [1:0] control_mode_select_in,
  input wire [3:0] gain_switch_condition_in,
  input wire gain_select_input_in,
  input wire switch_cond_met_in,
  input wire adapt_update_in,
  input wire [6:0] adapt_index_in,
  input wire nv_restore_in,
  input wire [6:0] nv_restore_index_in,
  output reg nv_save_out,
  output reg [6:0] nv_save_index_out,
  output reg overrun_check_en_out,
  output reg [15:0] overrun_travel_limit_out,
  output reg vib_ctrl_en_out,
  output reg [15:0] vibration_control_frequency_out,
  output reg [15:0] vibration_filter_adjust_out,
  output reg [6:0] adaptive_table_index_out,
  output reg [10:0] notch_freq_hz_out,
  output reg notch_en_out,
  output reg gain_set2_out,
  output reg speed_p_only_out
);

  // parameter storage
  // index is 7 bits: 0 to 64 fits
  reg [15:0] overrun_travel_limit;
  reg [15:0] vibration_control_frequency;
  reg [15:0] vibration_filter_adjust;
  reg [6:0] adaptive_table_index;
  reg gain_switch_mode_select;
  reg reject_flag;
  reg adapt_en_q;

  // save timer state
  // 32 bits cover the full save period
  reg [31:0] tick_cnt;
  reg tick;
  reg [31:0] save_cnt;

  // decoded write strobes and the status read strobe
  wire wr_overrun;
  wire wr_vib_freq;
  wire wr_vib_filt;
  wire wr_adapt_idx;
  wire wr_gain_mode;
  wire rd_status;

  // range checks
  wire overrun_ok;
  wire vib_freq_ok;
  wire vib_filt_ok;
  wire adapt_idx_ok;
  wire gain_mode_ok;
  wire bad_write;

  // adaptive filter state
  wire adapt_mode_on;
  wire adapt_en;
  wire adapt_fall;

  // table lookup results
  wire [10:0] table_freq;
  wire table_on;

  // gain selection
  reg next_gain_set2;
  reg next_p_only;

  // status word
  reg [15:0] status_word;

  // address decode of single-cycle write and read strobes
  // unmatched addresses are dropped
  assign wr_overrun = reg_wr_in && (reg_addr_in == `STPU_ADDR_OVERRUN);
  assign wr_vib_freq = reg_wr_in && (reg_addr_in == `STPU_ADDR_VIB_FREQ);
  assign wr_vib_filt = reg_wr_in && (reg_addr_in == `STPU_ADDR_VIB_FILT);
  assign wr_adapt_idx = reg_wr_in && (reg_addr_in == `STPU_ADDR_ADAPT_IDX);
  assign wr_gain_mode = reg_wr_in && (reg_addr_in == `STPU_ADDR_GAIN_MODE);
  assign rd_status = reg_rd_in && (reg_addr_in == `STPU_ADDR_STATUS);

  // setting range checks per parameter
  // a bad value leaves the register as it was
  assign overrun_ok = (reg_wdata_in <= `STPU_OVERRUN_MAX);
  assign vib_freq_ok = (reg_wdata_in <= `STPU_VIB_FREQ_MAX);
  assign vib_filt_ok = ($signed(reg_wdata_in) >= $signed(`STPU_VIB_FILT_MIN)) &&
                       ($signed(reg_wdata_in) <= $signed(`STPU_VIB_FILT_MAX));
  assign adapt_idx_ok = (reg_wdata_in <= {9'h000, `STPU_ADAPT_IDX_MAX});
  assign gain_mode_ok = (reg_wdata_in[15:1] == 15'h0000);

  // any write whose value is outside range, or that is locked out
  assign bad_write = (wr_overrun && !overrun_ok) ||
                     (wr_vib_freq && !vib_freq_ok) ||
                     (wr_vib_filt && !vib_filt_ok) ||
                     (wr_adapt_idx && (!adapt_idx_ok || adapt_en)) ||
                     (wr_gain_mode && !gain_mode_ok);

  // adaptive filter enable: modes 1..3 and 7 with advanced position control
  // other control modes keep the filter off
  assign adapt_mode_on = ((realtime_autotune_mode_in >= 3'h1) && (realtime_autotune_mode_in <= 3'h3)) ||
                         (realtime_autotune_mode_in == `STPU_ATM_ADAPT_ONLY);
  assign adapt_en = adapt_mode_on && (control_mode_select_in == `STPU_CTRL_ADVANCED);
  assign adapt_fall = adapt_en_q && !adapt_en;

  // remember last enable to see it drop
  // reset low: no false drop after reset
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      adapt_en_q <= 1'b0;
    end else begin
      adapt_en_q <= adapt_en;
    end
  end

  // overrun limit register
  // zero turns the travel check off downstream
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      overrun_travel_limit <= `STPU_RST_OVERRUN;
    end else if (wr_overrun && overrun_ok) begin
      overrun_travel_limit <= reg_wdata_in;
    end
  end

  // vibration frequency register
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      vibration_control_frequency <= `STPU_RST_VIB_FREQ;
    end else if (wr_vib_freq && vib_freq_ok) begin
      vibration_control_frequency <= reg_wdata_in;
    end
  end

  // vibration filter register, signed
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      vibration_filter_adjust <= `STPU_RST_VIB_FILT;
    end else if (wr_vib_filt && vib_filt_ok) begin
      vibration_filter_adjust <= reg_wdata_in;
    end
  end

  // gain switching mode register
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      gain_switch_mode_select <= `STPU_RST_GAIN_MODE;
    end else if (wr_gain_mode && gain_mode_ok) begin
      gain_switch_mode_select <= reg_wdata_in[0];
    end
  end

  // adaptive table index: restore, clear on disable, tracking, software write
  // restore wins so a power-up value is kept;
  // the clear acts on the falling enable only,
  // so software may set it while the filter is off
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      adaptive_table_index <= `STPU_RST_ADAPT_IDX;
    end else if (nv_restore_in && (nv_restore_index_in <= `STPU_ADAPT_IDX_MAX)) begin
      adaptive_table_index <= nv_restore_index_in;
    end else if (adapt_fall) begin
      adaptive_table_index <= 7'h00;
    end else if (adapt_en) begin
      if (adapt_update_in && (adapt_index_in <= `STPU_ADAPT_IDX_MAX)) begin
        adaptive_table_index <= adapt_index_in;
      end
    end else if (wr_adapt_idx && adapt_idx_ok) begin
      adaptive_table_index <= reg_wdata_in[6:0];
    end
  end

  // sticky rejected-write flag, cleared by reading status; a new reject wins
  // set before clear: a reject in the read cycle stays
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      reject_flag <= 1'b0;
    end else if (bad_write) begin
      reject_flag <= 1'b1;
    end else if (rd_status) begin
      reject_flag <= 1'b0;
    end
  end

  // millisecond tick divider
  // a shared tick keeps the save counter short
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // periodic save of the index while the adaptive filter runs
  // off restarts the count: a save follows
  // a full period of unbroken running
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      save_cnt <= 32'h00000000;
      nv_save_out <= 1'b0;
      nv_save_index_out <= 7'h00;
    end else begin
      nv_save_out <= 1'b0;
      if (!adapt_en) begin
        save_cnt <= 32'h00000000;
      end else if (tick) begin
        if (save_cnt >= SAVE_TICKS - 1) begin
          save_cnt <= 32'h00000000;
          nv_save_out <= 1'b1;
          nv_save_index_out <= adaptive_table_index;
        end else begin
          save_cnt <= save_cnt + 32'h00000001;
        end
      end
    end
  end

  // notch table lookup
  // combinational; registered with the outputs
  stpu_notch_table u_table (
    .index_in(adaptive_table_index),
    .rigidity_in(machine_rigidity_level_in),
    .freq_hz_out(table_freq),
    .notch_on_out(table_on)
  );

  // gain set and speed loop mode selection
  // codes 3 and 5 up are judged outside;
  // here they only pick the result used
  always @* begin
    next_gain_set2 = 1'b0;
    next_p_only = 1'b0;
    if (!gain_switch_mode_select) begin
      next_p_only = gain_select_input_in;
    end else begin
      case (gain_switch_condition_in)
        `STPU_GSC_ALWAYS1: next_gain_set2 = 1'b0;
        `STPU_GSC_ALWAYS2: next_gain_set2 = 1'b1;
        `STPU_GSC_INPUT: next_gain_set2 = gain_select_input_in;
        `STPU_GSC_ALWAYS1B: next_gain_set2 = 1'b0;
        default: next_gain_set2 = switch_cond_met_in;
      endcase
    end
  end

  // registered outputs towards the control loops
  // loops see one settled value per cycle
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      overrun_check_en_out <= 1'b0;
      overrun_travel_limit_out <= 16'h0000;
      vib_ctrl_en_out <= 1'b0;
      vibration_control_frequency_out <= 16'h0000;
      vibration_filter_adjust_out <= 16'h0000;
      adaptive_table_index_out <= 7'h00;
      notch_freq_hz_out <= 11'h000;
      notch_en_out <= 1'b0;
      gain_set2_out <= 1'b0;
      speed_p_only_out <= 1'b0;
    end else begin
      overrun_check_en_out <= (overrun_travel_limit != 16'h0000);
      overrun_travel_limit_out <= overrun_travel_limit;
      vib_ctrl_en_out <= (vibration_control_frequency >= `STPU_VIB_FREQ_MIN_ON);
      vibration_control_frequency_out <= vibration_control_frequency;
      vibration_filter_adjust_out <= vibration_filter_adjust;
      adaptive_table_index_out <= adaptive_table_index;
      notch_freq_hz_out <= table_freq;
      notch_en_out <= adapt_en && table_on;
      gain_set2_out <= next_gain_set2;
      speed_p_only_out <= next_p_only;
    end
  end

  // status word: reserved bits read as zero
  // bit 3 is the entry state before the enable gate
  always @* begin
    status_word = 16'h0000;
    status_word[`STPU_ST_ADAPT_EN] = adapt_en;
    status_word[`STPU_ST_REJECT] = reject_flag;
    status_word[`STPU_ST_GAIN_SET2] = next_gain_set2;
    status_word[`STPU_ST_NOTCH_ON] = table_on;
  end

  // read data, valid in the cycle after the read strobe
  // zero outside the answer cycle
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `STPU_ADDR_OVERRUN: reg_rdata_out <= overrun_travel_limit;
        `STPU_ADDR_VIB_FREQ: reg_rdata_out <= vibration_control_frequency;
        `STPU_ADDR_VIB_FILT: reg_rdata_out <= vibration_filter_adjust;
        `STPU_ADDR_ADAPT_IDX: reg_rdata_out <= {9'h000, adaptive_table_index};
        `STPU_ADDR_GAIN_MODE: reg_rdata_out <= {15'h0000, gain_switch_mode_select};
        `STPU_ADDR_STATUS: reg_rdata_out <= status_word;
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule // stpu_tuning_unit

// ===== bench/stpu_tuning_unit_asserts.sv
// port-level checks for the servo tuning unit
`timescale 1ns/1ps
module stpu_tuning_unit_asserts (
  input logic clk_sys_in,
  input logic rst_in,
  input logic [3:0] machine_rigidity_level_in,
  input logic [3:0] gain_switch_condition_in,
  input logic gain_select_input_in,
  input logic nv_save_out,
  input logic overrun_check_en_out,
  input logic [15:0] overrun_travel_limit_out,
  input logic vib_ctrl_en_out,
  input logic [15:0] vibration_control_frequency_out,
  input logic [15:0] vibration_filter_adjust_out,
  input logic [6:0] adaptive_table_index_out,
  input logic [10:0] notch_freq_hz_out,
  input logic notch_en_out,
  input logic gain_set2_out,
  input logic speed_p_only_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // high table entries that the rigidity level switches off
  function automatic bit cut(input logic [6:0] i, input logic [3:0] r);
    return (i >= 49 && i <= 53 && r >= 15) || (i >= 54 && i <= 58 && r >= 14) || (i == 59 && r >= 13);
  endfunction
  // held settings stay in range and drive their enables
  a_overrun_gate: assert property (overrun_check_en_out == (overrun_travel_limit_out != 16'h0000))
    else $error("overrun check enable wrong");
  a_overrun_range: assert property (overrun_travel_limit_out <= 16'h03E8)
    else $error("overrun limit out of range");
  a_vib_gate: assert property (vib_ctrl_en_out == (vibration_control_frequency_out >= 16'h0064))
    else $error("vibration enable wrong");
  a_vib_range: assert property (vibration_control_frequency_out <= 16'h1388)
    else $error("vibration frequency out of range");
  a_filt_range: assert property ($signed(vibration_filter_adjust_out) >= -200 && $signed(vibration_filter_adjust_out) <= 2500)
    else $error("vibration filter out of range");
  a_index_range: assert property (adaptive_table_index_out <= 7'h40)
    else $error("table index out of range");
  // notch table ends and rigidity cut
  a_notch_ends: assert property ((adaptive_table_index_out < 5 || adaptive_table_index_out > 59) |-> !notch_en_out && notch_freq_hz_out == 11'h000)
    else $error("notch active on a dead entry");
  a_rigid_cut: assert property (cut(adaptive_table_index_out, $past(machine_rigidity_level_in)) && cut(adaptive_table_index_out, $past(machine_rigidity_level_in, 2)) |-> !notch_en_out)
    else $error("notch active despite rigidity");
  // gain selection follows its causes
  a_gain2_cause: assert property (gain_set2_out |-> $past(gain_switch_condition_in) != 4'h0 && $past(gain_switch_condition_in) != 4'h4)
    else $error("gain set 2 under an always-gain-1 condition");
  a_p_only_cause: assert property (speed_p_only_out |-> $past(gain_select_input_in) && !gain_set2_out)
    else $error("p-only loop without select input");
  a_save_pulse: assert property (nv_save_out |=> !nv_save_out [*8])
    else $error("save requests too close");
  c_notch: cover property (notch_en_out);
  c_save: cover property (nv_save_out);
  c_gain2: cover property (gain_set2_out);
endmodule // stpu_tuning_unit_asserts
bind stpu_tuning_unit stpu_tuning_unit_asserts i_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .machine_rigidity_level_in(machine_rigidity_level_in), .gain_switch_condition_in(gain_switch_condition_in),
  .gain_select_input_in(gain_select_input_in), .nv_save_out(nv_save_out), .overrun_check_en_out(overrun_check_en_out),
  .overrun_travel_limit_out(overrun_travel_limit_out), .vib_ctrl_en_out(vib_ctrl_en_out),
  .vibration_control_frequency_out(vibration_control_frequency_out),
  .vibration_filter_adjust_out(vibration_filter_adjust_out), .adaptive_table_index_out(adaptive_table_index_out),
  .notch_freq_hz_out(notch_freq_hz_out), .notch_en_out(notch_en_out), .gain_set2_out(gain_set2_out),
  .speed_p_only_out(speed_p_only_out));

// ===== bench/test_stpu_tuning_unit.sv
// self-checking bench for the servo tuning unit
`timescale 1ns/1ps
module test_stpu_tuning_unit;
  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("unexpected %0t got %h exp %h", $time, g, e); end end
  logic clk_sys_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, gain_select_input_in = 0, switch_cond_met_in = 0;
  logic adapt_update_in = 0, nv_restore_in = 0, nv_save_out, overrun_check_en_out, vib_ctrl_en_out, notch_en_out;
  logic gain_set2_out, speed_p_only_out, adapt = 0, g, cm, e;
  logic [7:0] reg_addr_in = 0, a;
  logic [15:0] reg_wdata_in = 0, reg_rdata_out, overrun_travel_limit_out, vibration_control_frequency_out, rdv;
  logic [15:0] vibration_filter_adjust_out;
  logic [2:0] realtime_autotune_mode_in = 0;
  logic [3:0] machine_rigidity_level_in = 0, gain_switch_condition_in = 0;
  logic [1:0] control_mode_select_in = 0;
  logic [6:0] adapt_index_in = 0, nv_restore_index_in = 0, nv_save_index_out, adaptive_table_index_out;
  logic [10:0] notch_freq_hz_out;
  logic [31:0] seed = 57;
  logic [23:0] bnd[16] = '{24'h000000, 24'h0003E8, 24'h0003E9, 24'h040063, 24'h040064, 24'h041388, 24'h041389,
    24'h08FF38, 24'h08FF37, 24'h0809C4, 24'h0809C5, 24'h0C0040, 24'h0C0041, 24'h100000, 24'h100002, 24'h180005};
  int fails = 0, n_tests = 0, k, t, f, mreg[5] = '{10, 0, 0, 0, 1};
  int ftab[55] = '{1482, 1426, 1372, 1319, 1269, 1221, 1174, 1130, 1087, 1045, 1005, 967, 930, 895, 861, 828, 796,
    766, 737, 709, 682, 656, 631, 607, 584, 562, 540, 520, 500, 481, 462, 445, 428, 412, 396, 381, 366, 352, 339,
    326, 314, 302, 290, 279, 269, 258, 248, 239, 230, 221, 213, 205, 197, 189, 182};
  stpu_tuning_unit #(.TICK_CYCLES(4), .SAVE_TICKS(5)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .realtime_autotune_mode_in(realtime_autotune_mode_in),
    .machine_rigidity_level_in(machine_rigidity_level_in), .control_mode_select_in(control_mode_select_in),
    .gain_switch_condition_in(gain_switch_condition_in), .gain_select_input_in(gain_select_input_in),
    .switch_cond_met_in(switch_cond_met_in), .adapt_update_in(adapt_update_in), .adapt_index_in(adapt_index_in),
    .nv_restore_in(nv_restore_in), .nv_restore_index_in(nv_restore_index_in), .nv_save_out(nv_save_out),
    .nv_save_index_out(nv_save_index_out), .overrun_check_en_out(overrun_check_en_out),
    .overrun_travel_limit_out(overrun_travel_limit_out), .vib_ctrl_en_out(vib_ctrl_en_out),
    .vibration_control_frequency_out(vibration_control_frequency_out),
    .vibration_filter_adjust_out(vibration_filter_adjust_out), .adaptive_table_index_out(adaptive_table_index_out),
    .notch_freq_hz_out(notch_freq_hz_out), .notch_en_out(notch_en_out), .gain_set2_out(gain_set2_out),
    .speed_p_only_out(speed_p_only_out));
  // 50 MHz system clock
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // xorshift step for random stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // entries switched off by rigidity
  function automatic bit cut(input int i, input int r);
    return (i >= 49 && i <= 53 && r >= 15) || (i >= 54 && i <= 58 && r >= 14) || (i == 59 && r >= 13);
  endfunction
  // accepted writes: inside the setting range, index only while adaptive is off
  function automatic bit ok(input logic [7:0] ad, input logic [15:0] d);
    case (ad)
      8'h00: return d <= 1000;
      8'h04: return d <= 5000;
      8'h08: return $signed(d) >= -200 && $signed(d) <= 2500;
      8'h0C: return d <= 64 && !adapt;
      8'h10: return d <= 1;
      default: return 0;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_sys_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 rdv = reg_rdata_out;
  endtask
  // write, update the model, read back and compare the settings outputs
  task automatic wm(input logic [7:0] ad, input logic [15:0] d);
    wr(ad, d);
    if (ok(ad, d)) mreg[ad[4:2]] = d;
    rd(ad);
    `CHK(rdv, ad < 8'h14 ? mreg[ad[4:2]][15:0] : 16'h0000)
    `CHK(overrun_travel_limit_out, mreg[0][15:0])
    `CHK(overrun_check_en_out, mreg[0] != 0)
    `CHK(vibration_control_frequency_out, mreg[1][15:0])
    `CHK(vib_ctrl_en_out, mreg[1] >= 100)
    `CHK(vibration_filter_adjust_out, mreg[2][15:0])
  endtask
  task automatic stop_test;
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (k = 0; k < 5; k++) begin
      rd(8'(k * 4));
      `CHK(rdv, mreg[k][15:0])
    end
    foreach (bnd[k]) wm(bnd[k][23:16], bnd[k][15:0]);
    wr(8'h10, 16'h0002);
    rd(8'h14);
    `CHK(rdv[1], 1'b1)
    for (k = 0; k < 30; k++) begin
      seed = xs(seed);
      a = 8'((seed % 6) * 4);
      wm(a == 8'h14 ? 8'h18 : a, seed[16] ? 16'(-int'(seed[31:20] % 300)) : 16'(seed[31:18] % 5600));
    end
    // gain switching off, then conditions 0 to 10 with switching on
    wm(8'h10, 16'h0000);
    for (k = 0; k < 17; k++) begin
      seed = xs(seed);
      g = seed[0];
      cm = seed[1];
      @(posedge clk_sys_in);
      gain_select_input_in <= g;
      switch_cond_met_in <= cm;
      gain_switch_condition_in <= 4'(k - 6);
      if (k == 6) wm(8'h10, 16'h0001);
      tick(2);
      e = k > 5 && ((k == 7) || (k == 8 && g) || ((k == 9 || k > 10) && cm));
      `CHK(speed_p_only_out, k < 6 && g)
      `CHK(gain_set2_out, e)
    end
    // adaptive filter on: estimator drives the index, writes refused
    @(posedge clk_sys_in);
    control_mode_select_in <= 2'h2;
    realtime_autotune_mode_in <= 3'h1;
    adapt = 1;
    wm(8'h0C, 16'h0009);
    for (k = 0; k < 67; k++) begin
      seed = xs(seed);
      @(posedge clk_sys_in);
      machine_rigidity_level_in <= seed[3:0];
      adapt_update_in <= 1'b1;
      adapt_index_in <= 7'(k);
      @(posedge clk_sys_in);
      adapt_update_in <= 1'b0;
      tick(2);
      if (k <= 64) mreg[3] = k;
      f = (mreg[3] >= 5 && mreg[3] <= 59) ? ftab[mreg[3] - 5] : 0;
      `CHK(adaptive_table_index_out, mreg[3][6:0])
      `CHK(notch_freq_hz_out, 11'(f))
      `CHK(notch_en_out, f != 0 && !cut(mreg[3], seed[3:0]))
    end
    // periodic save of the index
    for (t = 0; t < 50 && nv_save_out !== 1'b1; t++) tick(1);
    `CHK(nv_save_out, 1'b1)
    `CHK(nv_save_index_out, mreg[3][6:0])
    for (t = 1; t < 50; t++) begin
      tick(1);
      if (nv_save_out === 1'b1) break;
    end
    `CHK(t, 20)
    // disable clears the index back to zero
    @(posedge clk_sys_in);
    realtime_autotune_mode_in <= 3'h4;
    tick(3);
    `CHK(adaptive_table_index_out, 7'h00)
    // power cycle: restore in the first cycle after release
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    nv_restore_in <= 1'b1;
    nv_restore_index_in <= 7'd30;
    @(posedge clk_sys_in);
    nv_restore_in <= 1'b0;
    realtime_autotune_mode_in <= 3'h7;
    tick(3);
    `CHK(adaptive_table_index_out, 7'd30)
    `CHK(notch_freq_hz_out, 11'd562)
    `CHK(overrun_travel_limit_out, 16'h000A)
    // index write refused while adaptive runs; status read clears the flag
    wr(8'h0C, 16'h0005);
    rd(8'h14);
    `CHK(rdv, ({12'h000, 1'b1, cm, 2'b11}))
    `CHK(adaptive_table_index_out, 7'd30)
    rd(8'h14);
    `CHK(rdv[1], 1'b0)
    stop_test;
  end
endmodule // test_stpu_tuning_unit
